// file: hdl/tcgen_top.sv
// Contract
// - four generator seeding modes select recorded code
// - clock seeded mode loads real-time clock
// - record continue resumes after last code
// - empty medium continues previous medium code
// - continuous mode counts always, start = count
// - external seeded takes incoming code at start
// - output selects replay or generator code
// - generator code only while generator runs
// - jam only accepted in continuous mode
// - rate mismatch ignores jam, flags illegal
// - accepted jam locks, takes over, flags
// - keeps counting on crystal after input loss
// - jam copies external user bits
// - auto marker 01 only on linear medium; the code gives it the lowest free number
// - at most 99 markers stored
// - marker key while recording stores time
// - new marker takes lowest free number
// - key while stopped lists markers, empty shown
// - seven selectable picture rates
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
module tcgen_top #(
  parameter int TC_W = 24,
  parameter int UB_W = 32
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Recorder state and panel pins
  input wire logic RECORDING,
  input wire logic NEW_FILE,
  input wire logic LINEAR_MEDIUM,
  input wire logic MARKER_KEY,
  input wire logic FRAME_TICK,
  input wire logic [TC_W-1:0] RTC_CODE,
  input wire logic [TC_W-1:0] REPLAY_CODE,
  input wire logic EXT_PRESENT,
  input wire logic EXT_FRAME,
  input wire logic [TC_W-1:0] EXT_CODE,
  input wire logic [UB_W-1:0] EXT_UBITS,
  input wire logic [2:0] EXT_RATE,
  output logic [TC_W-1:0] TIMECODE_OUTPUT_SELECT,
  output logic [UB_W-1:0] UB_OUT,
  output logic TIMECODE_OUTPUT_SELECT_VALID,
  output logic SHOW_MARKER,
  output logic [6:0] SHOW_NUM
);
  import tcgen_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 7;
  logic [SW-1:0] sy1_r;    // First stage, read only by the second
  logic [SW-1:0] sy2_r;    // Clean levels
  logic [SW-1:0] sy_prev_r; // For edge detection
  logic [TC_W-1:0] ext_code_r; // Bus values sampled on a clean frame edge
  logic [UB_W-1:0] ext_ub_r;
  logic [2:0] ext_rate_r;

  // Multi-bit data is only sampled after the strobe settles
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy_prev_r <= '0;
    end else begin
      sy1_r <= {RECORDING, NEW_FILE, LINEAR_MEDIUM, MARKER_KEY, FRAME_TICK,
                EXT_PRESENT, EXT_FRAME};
      sy2_r <= sy1_r;
      sy_prev_r <= sy2_r;
    end
  end

  logic rec_w, newf_w, lin_w, key_w, tick_w, extp_w, extf_w;
  assign {rec_w, newf_w, lin_w, key_w, tick_w, extp_w, extf_w} = sy2_r;
  logic rec_rise, newf_rise, key_rise, tick_rise, extf_rise;
  assign rec_rise = rec_w & ~sy_prev_r[6];
  assign newf_rise = newf_w & ~sy_prev_r[5];
  assign key_rise = key_w & ~sy_prev_r[3];
  assign tick_rise = tick_w & ~sy_prev_r[2];
  assign extf_rise = extf_w & ~sy_prev_r[0];

  // External code latched each external frame
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_code_r <= '0;
      ext_ub_r <= '0;
      ext_rate_r <= 3'h0;
    end else if (extf_rise) begin
      ext_code_r <= EXT_CODE;
      ext_ub_r <= EXT_UBITS;
      ext_rate_r <= EXT_RATE;
    end
  end

  // ----------------------------------------------------------------
  // Control registers and AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [8:0] ctrl_r;       // Mode, source, rate, auto marker
  logic [6:0] mksel_r;      // Listing index
  logic aw_ok_r, w_ok_r;    // Address and data captured
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic jam_cmd, clr_cmd, newmed_cmd; // One-cycle command pulses

  tcgen_mode_t mode_w;
  tcgen_rate_t rate_w;
  assign mode_w = tcgen_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign rate_w = tcgen_rate_t'(ctrl_r[CTRL_RATE_LSB +: 3]);

  logic wr_go;
  assign wr_go = aw_ok_r & w_ok_r & ~S_AXI_BVALID;

  // Address and data may arrive in either order
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else begin
      S_AXI_AWREADY <= ~aw_ok_r & ~S_AXI_AWREADY & S_AXI_AWVALID;
      S_AXI_WREADY <= ~w_ok_r & ~S_AXI_WREADY & S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_ok_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_ok_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= known(awaddr_r) ? 2'h0 : 2'h2;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Decodes an address shared by the write and read paths
  function automatic logic known(input logic [7:0] a);
    known = (a <= MKLAST_OFS) && (a[1:0] == 2'h0);
  endfunction : known

  // Writable registers; only byte lanes that matter are honoured
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= CTRL_RST;
      mksel_r <= 7'h00;
    end else if (wr_go) begin
      if (awaddr_r == CTRL_OFS) begin
        if (wstrb_r[0]) ctrl_r[7:0] <= wdata_r[7:0];
        if (wstrb_r[1]) ctrl_r[8] <= wdata_r[CTRL_AUTO_BIT];
      end else if (awaddr_r == MKSEL_OFS) begin
        if (wstrb_r[0]) mksel_r <= wdata_r[6:0];
      end
    end
  end

  assign jam_cmd = wr_go && awaddr_r == CMD_OFS && wstrb_r[0] && wdata_r[CMD_JAM_BIT];
  assign clr_cmd = wr_go && awaddr_r == CMD_OFS && wstrb_r[0] && wdata_r[CMD_CLR_BIT];
  assign newmed_cmd = wr_go && awaddr_r == CMD_OFS && wstrb_r[0] && wdata_r[CMD_NEWMED_BIT];

  // ----------------------------------------------------------------
  // Generator
  // ----------------------------------------------------------------
  logic [TC_W-1:0] gen_r;    // Running frame count
  logic [TC_W-1:0] last_r;   // Last recorded code, survives medium change
  logic [UB_W-1:0] ub_r;
  logic gen_run_w;
  logic jam_pend_r;          // Waiting for the next external frame to lock
  logic void_r, illrate_r, jamd_r;

  // Generator runs always when continuous, else only while recording
  assign gen_run_w = (mode_w == TCGEN_CONTINUOUS) || rec_w;

  // Seeding and counting; jam lock takes the external frame edge as timing
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gen_r <= '0;
      last_r <= '0;
    end else if (jam_pend_r && extf_rise) begin
      gen_r <= ext_code_r + TC_W'(1);
    end else if (rec_rise || (rec_w && newf_rise)) begin
      case (mode_w)
        TCGEN_CLOCK_SEEDED: gen_r <= RTC_CODE;
        TCGEN_RECORD_CONTINUE: gen_r <= last_r + TC_W'(1);
        TCGEN_EXTERNAL_SEEDED: gen_r <= ext_code_r;
        default: gen_r <= gen_r;
      endcase
    end else if (gen_run_w && tick_rise) begin
      gen_r <= gen_r + TC_W'(1);
      if (rec_w) last_r <= gen_r + TC_W'(1);
    end
  end

  // User bits copied only by a jam
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ub_r <= '0;
    end else if (jam_pend_r && extf_rise) begin
      ub_r <= ext_ub_r;
    end
  end

  // Jam request checks; a flag set wins over the clear command, but a lock or mode change clears jam_pend_r over a new jam
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      jam_pend_r <= 1'b0;
      void_r <= 1'b0;
      illrate_r <= 1'b0;
      jamd_r <= 1'b0;
    end else begin
      if (clr_cmd) begin
        void_r <= 1'b0;
        illrate_r <= 1'b0;
        jamd_r <= 1'b0;
      end
      if (jam_cmd) begin
        if (mode_w != TCGEN_CONTINUOUS) void_r <= 1'b1;
        else if (!extp_w || ext_rate_r != 3'(rate_w)) illrate_r <= 1'b1;
        else jam_pend_r <= 1'b1;
      end
      if (jam_pend_r && (extf_rise || mode_w != TCGEN_CONTINUOUS)) begin
        jam_pend_r <= 1'b0;
        if (extf_rise) jamd_r <= 1'b1;
      end
    end
  end

  // Output source selection
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TIMECODE_OUTPUT_SELECT <= '0;
      UB_OUT <= '0;
      TIMECODE_OUTPUT_SELECT_VALID <= 1'b0;
    end else if (ctrl_r[CTRL_OUT_BIT] == TCGEN_REPLAY) begin
      TIMECODE_OUTPUT_SELECT <= REPLAY_CODE;
      UB_OUT <= '0;
      TIMECODE_OUTPUT_SELECT_VALID <= 1'b1;
    end else begin
      TIMECODE_OUTPUT_SELECT <= gen_r;
      UB_OUT <= ub_r;
      TIMECODE_OUTPUT_SELECT_VALID <= gen_run_w;
    end
  end

  // ----------------------------------------------------------------
  // Marker store
  // ----------------------------------------------------------------
  localparam int SHOW_W = $clog2(SHOW_CYC + 1);
  logic [TC_W-1:0] mk_time_r [MARKER_MAX];
  logic [MARKER_MAX-1:0] mk_used_r;
  logic [6:0] free_idx;
  logic free_ok;
  logic [SHOW_W-1:0] show_cnt_r;
  logic list_r;
  logic store_go;

  // Lowest free slot, scanning from the top so the lowest wins
  always_comb begin
    free_idx = 7'h00;
    free_ok = 1'b0;
    for (int i = MARKER_MAX - 1; i >= 0; i--) begin
      if (!mk_used_r[i]) begin
        free_idx = 7'(i);
        free_ok = 1'b1;
      end
    end
  end

  // Auto marker needs any free slot and takes the lowest one, like a key press
  assign store_go = free_ok && ((rec_w && key_rise) ||
                    (rec_rise && ctrl_r[CTRL_AUTO_BIT] && lin_w));

  generate
    for (genvar g = 0; g < MARKER_MAX; g++) begin : g_mk
      always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
          mk_used_r[g] <= 1'b0;
          mk_time_r[g] <= '0;
        end else if (store_go && free_idx == 7'(g)) begin
          mk_used_r[g] <= 1'b1;
          mk_time_r[g] <= rec_rise ? TIMECODE_OUTPUT_SELECT : gen_r;
        end
      end
    end
  endgenerate

  // Display timer and list mode
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      show_cnt_r <= '0;
      SHOW_MARKER <= 1'b0;
      SHOW_NUM <= 7'h00;
      list_r <= 1'b0;
    end else begin
      if (store_go) begin
        show_cnt_r <= SHOW_W'(SHOW_CYC);
        SHOW_MARKER <= 1'b1;
        SHOW_NUM <= free_idx + 7'h01;
      end else if (show_cnt_r != '0) begin
        show_cnt_r <= show_cnt_r - SHOW_W'(1);
        SHOW_MARKER <= show_cnt_r != SHOW_W'(1);
      end
      if (key_rise && !rec_w) list_r <= ~list_r;
      else if (rec_w) list_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_w;
  logic [6:0] sel_w;
  assign sel_w = (mksel_r < 7'(MARKER_MAX)) ? mksel_r : 7'h00;

  always_comb begin
    rd_w = 32'h0000_0000;
    if (S_AXI_ARADDR == CTRL_OFS) rd_w = {23'h0, ctrl_r};
    else if (S_AXI_ARADDR == STAT_OFS)
      rd_w = {26'h0, list_r, rec_w, ~free_ok, jamd_r, illrate_r, void_r};
    else if (S_AXI_ARADDR == GENTC_OFS) rd_w = 32'(gen_r);
    else if (S_AXI_ARADDR == GENUB_OFS) rd_w = 32'(ub_r);
    else if (S_AXI_ARADDR == SEED_OFS) rd_w = 32'(last_r);
    else if (S_AXI_ARADDR == MKSEL_OFS) rd_w = {25'h0, mksel_r};
    else if (S_AXI_ARADDR == MKDAT_OFS)                  // unused slot reads empty
      rd_w = mk_used_r[sel_w] ? {1'b1, 7'h0, 24'(mk_time_r[sel_w])} : 32'h0000_0000;
    else if (S_AXI_ARADDR == MKLAST_OFS) rd_w = {25'h0, SHOW_NUM};
  end

  // One read at a time; answer the cycle after the address is taken
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'h0;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_w;
        S_AXI_RRESP <= known(S_AXI_ARADDR) ? 2'h0 : 2'h2;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Empty-medium command marks the carried value as the seed already held
  logic newmed_seen_r;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) newmed_seen_r <= 1'b0;
    else if (newmed_cmd) newmed_seen_r <= 1'b1;
    else if (rec_rise) newmed_seen_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_jam_void: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    jam_cmd && mode_w != TCGEN_CONTINUOUS |=> void_r && !jam_pend_r)
    else $error("jam outside continuous mode not refused");
  a_rate_bad: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    jam_cmd && mode_w == TCGEN_CONTINUOUS && ext_rate_r != 3'(rate_w)
    |=> illrate_r && !jam_pend_r)
    else $error("rate mismatch jam not ignored");
  a_jam_lock: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    jam_pend_r && extf_rise |=> jamd_r && gen_r == $past(ext_code_r) + TC_W'(1))
    else $error("jam did not lock to external code");
  a_jam_ubits: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    jam_pend_r && extf_rise |=> ub_r == $past(ext_ub_r))
    else $error("user bits not copied");
  a_gen_idle: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ctrl_r[CTRL_OUT_BIT] && !gen_run_w |=> !TIMECODE_OUTPUT_SELECT_VALID)
    else $error("generator code while stopped");
  a_rtc_seed: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    rec_rise && mode_w == TCGEN_CLOCK_SEEDED && !jam_pend_r |=> gen_r == $past(RTC_CODE))
    else $error("clock seed not loaded");
  a_mk_full: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !free_ok |=> $stable(mk_used_r))
    else $error("marker stored while full");
  a_mk_show: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    store_go |=> SHOW_MARKER && SHOW_NUM == $past(free_idx) + 7'h01)
    else $error("marker number not shown");

endmodule : tcgen_top

// file: shared/tcgen_pkg.sv
package tcgen_pkg;

  // ----------------------------------------------------------------
  // AXI4-Lite register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;      // Mode, output source, rate, auto marker
  localparam logic [7:0] CMD_OFS = 8'h04;       // Write-one command strobes
  localparam logic [7:0] STAT_OFS = 8'h08;      // Sticky indications and live state
  localparam logic [7:0] GENTC_OFS = 8'h0C;     // Generator frame count
  localparam logic [7:0] GENUB_OFS = 8'h10;     // Generator user bits
  localparam logic [7:0] SEED_OFS = 8'h14;      // Seed value for a fresh medium
  localparam logic [7:0] MKSEL_OFS = 8'h18;     // Marker slot index for listing
  localparam logic [7:0] MKDAT_OFS = 8'h1C;     // Selected marker time, bit 31 = valid
  localparam logic [7:0] MKLAST_OFS = 8'h20;    // Last stored marker number

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;             // Two bits
  localparam int CTRL_OUT_BIT = 2;
  localparam int CTRL_RATE_LSB = 4;             // Three bits
  localparam int CTRL_AUTO_BIT = 8;
  localparam int CMD_JAM_BIT = 0;
  localparam int CMD_CLR_BIT = 1;               // Clear sticky indications
  localparam int CMD_NEWMED_BIT = 2;            // Empty medium inserted
  localparam int ST_VOID_BIT = 0;
  localparam int ST_ILLRATE_BIT = 1;
  localparam int ST_JAM_BIT = 2;
  localparam int ST_FULL_BIT = 3;
  localparam int ST_RUN_BIT = 4;
  localparam int ST_LIST_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [8:0] CTRL_RST = 9'h000;     // Auto marker off by default
  localparam int MARKER_MAX = 99;
  localparam int SHOW_NS = 2000;                // Marker number display time
  localparam int CLK_MHZ = 250;
  localparam int SHOW_CYC = (SHOW_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCGEN_CLOCK_SEEDED, TCGEN_RECORD_CONTINUE, TCGEN_CONTINUOUS, TCGEN_EXTERNAL_SEEDED
  } tcgen_mode_t;

  typedef enum logic [2:0] {
    TCGEN_R23976, TCGEN_R24, TCGEN_R25, TCGEN_R2997, TCGEN_R2997DF, TCGEN_R30DF, TCGEN_R30
  } tcgen_rate_t;

  typedef enum logic {TCGEN_REPLAY, TCGEN_GEN} tcgen_src_t;

endpackage : tcgen_pkg

// file: tb/tcgen_ext_model.sv
// ----------------------------------------------------------------
// External time code source, frame strobe plus code and user bits
// ----------------------------------------------------------------
module tcgen_ext_model #(
  parameter int PERIOD = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic load,
  input wire logic present_en,
  input wire logic [23:0] start_code,
  input wire logic [31:0] ubits_in,
  input wire logic [2:0] rate_in,
  output logic present,
  output logic frame,
  output logic [23:0] code,
  output logic [31:0] ubits,
  output logic [2:0] rate
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_r; // Cycle position within one frame

  // Frame strobe and code; a stalled source simply holds its last frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 0;
      frame <= 1'b0;
      code <= 24'h000000;
    end else if (!present_en) begin
      frame <= 1'b0;
      code <= ~code; // Cable pulled: no stale value may look valid
    end else if (load) begin
      code <= start_code;
    end else if (run) begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      frame <= (cnt_r < PERIOD / 2);
      if (cnt_r == 0) begin
        code <= code + 24'h000001; // New value lands with the rising strobe
      end
    end
  end

  // User bits and rate follow the source settings while connected
  always_ff @(posedge clk) begin
    present <= present_en;
    ubits <= present_en ? ubits_in : ~ubits;
    rate <= rate_in;
  end
endmodule : tcgen_ext_model

// file: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tcgen_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tvalid, show;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, g, xub, ubo, ubq;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic rec, nfile, lin, key, tick, xrun, xload, xpres, xp, xf;
  logic [23:0] rtc, rply, tcout, xstart, xcode;
  logic [2:0] xrate, xr;
  logic [6:0] snum;
  int errors, comparisons, seed;

  tcgen_top tcgen_top_inst (.REF_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .RECORDING(rec), .NEW_FILE(nfile), .LINEAR_MEDIUM(lin),
    .MARKER_KEY(key), .FRAME_TICK(tick), .RTC_CODE(rtc), .REPLAY_CODE(rply),
    .EXT_PRESENT(xp), .EXT_FRAME(xf), .EXT_CODE(xcode), .EXT_UBITS(ubo),
    .EXT_RATE(xr), .TIMECODE_OUTPUT_SELECT(tcout), .UB_OUT(ubq), .TIMECODE_OUTPUT_SELECT_VALID(tvalid),
    .SHOW_MARKER(show), .SHOW_NUM(snum));

  tcgen_ext_model tcgen_ext_model_inst (.clk(clk), .rst_n(rst_n), .run(xrun),
    .load(xload), .present_en(xpres), .start_code(xstart), .ubits_in(xub),
    .rate_in(xrate), .present(xp), .frame(xf), .code(xcode), .ubits(ubo), .rate(xr));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // A hung handshake must end the run rather than stall it
  task automatic guard(inout int n);
    n++;
    if (n > 200) begin
      errors++;
      $display("FAIL axi handshake expected answer seen timeout");
      complete_run();
    end
  endtask : guard

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w || bvalid !== 1'b1) begin
      @(posedge clk);
      guard(n);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk); // Let an edge pass so the next call never reassigns bready at once
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int n;
    logic ar;
    n = 0;
    ar = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (ar || rvalid !== 1'b1) begin
      @(posedge clk);
      guard(n);
      if (ar && arready === 1'b1) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk); // Same spacing for back-to-back reads
  endtask : rdr

  task automatic pulse_tick;
    tick <= 1'b1;
    cyc(3);
    tick <= 1'b0;
    cyc(3);
  endtask : pulse_tick

  task automatic press;
    key <= 1'b1;
    cyc(6);
    key <= 1'b0;
    cyc(6);
  endtask : press

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h0E6A;
    errors = 0;
    comparisons = 0;
    {awvalid, wvalid, bready, arvalid, rready, rec, nfile, lin, key, tick} = 10'h000;
    {xrun, xload, xpres} = 3'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    rtc = 24'($random(seed));
    rply = 24'($random(seed));
    xstart = 24'($random(seed));
    xub = $random(seed);
    xrate = 3'h2;
    rst_n = 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(1);
    rdr(CTRL_OFS);
    chk("ctrl reset", {23'h0, CTRL_RST}, rd);
    rdr(8'h40);
    chk("rresp unmapped", 32'h2, {30'h0, rs});
    wr(8'h40, 32'h0);
    chk("bresp unmapped", 32'h2, {30'h0, rs});
    for (int r = 0; r < 7; r++) begin
      wr(CTRL_OFS, 32'(r) << CTRL_RATE_LSB);
      rdr(CTRL_OFS);
      chk("rate field", 32'(r) << CTRL_RATE_LSB, rd);
    end
    $display("test map done");
    // Output source and generator running state
    wr(CTRL_OFS, 32'h0);
    cyc(8);
    chk("tc replay", {8'h0, rply}, {8'h0, tcout});
    wr(CTRL_OFS, 32'h4);
    cyc(8);
    chk("valid idle", 32'h0, {31'h0, tvalid});
    rec <= 1'b1;
    cyc(8);
    chk("valid rec", 32'h1, {31'h0, tvalid});
    rdr(GENTC_OFS);
    chk("clock seed", {8'h0, rtc}, rd);
    repeat (3) pulse_tick();
    rec <= 1'b0;
    cyc(8);
    rdr(SEED_OFS);
    chk("last code", {8'h0, rtc + 24'h3}, rd);
    wr(CTRL_OFS, 32'h5);
    rec <= 1'b1;
    cyc(8);
    rdr(GENTC_OFS);
    chk("continue", {8'h0, rtc + 24'h4}, rd);
    repeat (2) pulse_tick();
    nfile <= 1'b1;
    cyc(8);
    nfile <= 1'b0;
    rdr(GENTC_OFS);
    chk("new file", {8'h0, rtc + 24'h7}, rd);
    rec <= 1'b0;
    cyc(8);
    wr(CMD_OFS, 32'h1 << CMD_NEWMED_BIT);
    rec <= 1'b1;
    cyc(8);
    rdr(GENTC_OFS);
    chk("new medium", {8'h0, rtc + 24'h7}, rd);
    rec <= 1'b0;
    wr(CTRL_OFS, 32'h6);
    cyc(8);
    chk("valid free", 32'h1, {31'h0, tvalid});
    rdr(GENTC_OFS);
    g = rd;
    repeat (2) pulse_tick();
    rec <= 1'b1;
    cyc(8);
    rdr(GENTC_OFS);
    chk("free count", (g + 32'h2) & 32'hFFFFFF, rd);
    rec <= 1'b0;
    $display("test seeding done");
    // External seed: source sends frames then stalls
    xpres <= 1'b1;
    xload <= 1'b1;
    cyc(1);
    xload <= 1'b0;
    xrun <= 1'b1;
    cyc(100);
    xrun <= 1'b0;
    cyc(10);
    wr(CTRL_OFS, 32'h23);
    rec <= 1'b1;
    cyc(8);
    rdr(GENTC_OFS);
    chk("ext seed", {8'h0, xcode}, rd);
    rec <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        wr(CTRL_OFS, 32'h20 | 32'(m));
        wr(CMD_OFS, 32'h2);
        wr(CMD_OFS, 32'h1);
        cyc(8);
        rdr(STAT_OFS);
        chk("jam void", 32'h1, rd & 32'h7);
      end
    end
    xrate <= 3'h3;
    xrun <= 1'b1;
    wr(CTRL_OFS, 32'h26);
    wr(CMD_OFS, 32'h2);
    wr(CMD_OFS, 32'h1);
    cyc(60);
    rdr(STAT_OFS);
    chk("jam rate", 32'h2, rd & 32'h7);
    xrate <= 3'h2;
    cyc(24);
    wr(CMD_OFS, 32'h2);
    wr(CMD_OFS, 32'h1);
    cyc(80);
    rdr(STAT_OFS);
    chk("jam taken", 32'h4, rd & 32'h7);
    rdr(GENUB_OFS);
    chk("jam ubits", xub, rd);
    chk("ub out", xub, ubq);
    xrun <= 1'b0;
    xpres <= 1'b0;
    cyc(8);
    rdr(GENTC_OFS);
    g = rd;
    repeat (4) pulse_tick();
    rdr(GENTC_OFS);
    chk("crystal run", (g + 32'h4) & 32'hFFFFFF, rd);
    $display("test jam done");
    // Markers: normal medium first, then linear medium filled up
    wr(CTRL_OFS, 32'h106);
    rec <= 1'b1;
    cyc(8);
    wr(MKSEL_OFS, 32'h0);
    rdr(MKDAT_OFS);
    chk("no auto normal", 32'h0, rd);
    rec <= 1'b0;
    lin <= 1'b1;
    cyc(8);
    rdr(GENTC_OFS);
    g = rd;
    rec <= 1'b1;
    cyc(8);
    rdr(MKDAT_OFS);
    chk("auto marker", 32'h80000000 | g, rd);
    wr(MKSEL_OFS, 32'h5);
    rdr(MKDAT_OFS);
    chk("empty slot", 32'h0, rd);
    for (int k = 2; k <= MARKER_MAX; k++) begin
      press();
      chk("show num", 32'h80 | 32'(k), {24'h0, show, snum});
      rdr(MKLAST_OFS);
      chk("marker num", 32'(k), rd);
    end
    rdr(STAT_OFS);
    chk("list full", 32'h8, rd & 32'h8);
    press();
    rdr(MKLAST_OFS);
    chk("full ignore", 32'(MARKER_MAX), rd);
    rec <= 1'b0;
    cyc(8);
    press();
    rdr(STAT_OFS);
    chk("listing", 32'h20, rd & 32'h20);
    $display("test markers done");
    complete_run();
  end
endmodule : testbench
